// [ipnp_regs.vh]
`ifndef IPNP_REGS_VH
`define IPNP_REGS_VH

// ------------------------------------------------------------
// isa port addresses
// ------------------------------------------------------------
`define IPNP_INDEX_PORT     16'h0279
`define IPNP_WRITE_PORT     16'h0A79
`define IPNP_RD_RANGE_HI    7'h01
`define IPNP_RD_LOW_BITS    2'h3

// ------------------------------------------------------------
// configuration register indices
// ------------------------------------------------------------
`define IPNP_REG_RDPORT     8'h00
`define IPNP_REG_ISOLATE    8'h01
`define IPNP_REG_CFGCTL     8'h02
`define IPNP_REG_WAKE       8'h03
`define IPNP_REG_RESDATA    8'h04
`define IPNP_REG_STATUS     8'h05
`define IPNP_REG_CSN        8'h06
`define IPNP_REG_ACTIVATE   8'h30

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IPNP_CTL_RESET_BIT  0
`define IPNP_CTL_WFK_BIT    1
`define IPNP_CTL_RSTCSN_BIT 2
`define IPNP_STS_VALID_BIT  0
`define IPNP_ACT_BIT        0
`define IPNP_FEAT_EN_BIT    0

// ------------------------------------------------------------
// reset values and patterns
// ------------------------------------------------------------
`define IPNP_CSN_RESET      8'h00
`define IPNP_INDEX_RESET    8'h00
`define IPNP_RDPORT_RESET   8'h00
`define IPNP_ISO_FIRST      8'h55
`define IPNP_ISO_SECOND     8'hAA

// ------------------------------------------------------------
// initiation key
// ------------------------------------------------------------
`define IPNP_KEY_FIRST      8'h6A
`define IPNP_KEY_LAST_IDX   5'h1F

`endif

// [ipnp_key_det.v]
`include "ipnp_regs.vh"

module ipnp_key_det (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       wr_i,
    input  wire [7:0] data_i,
    output reg        match_o
);

    reg  [7:0] expect_byte;
    reg  [4:0] count;
    wire       hit;

    // key bytes follow a shift sequence from the first byte
    function [7:0] key_next;
        input [7:0] b;
        begin
            key_next = {b[0] ^ b[1], b[7:1]};
        end
    endfunction

    assign hit = (data_i == expect_byte);

    always @(posedge clk_i) begin
        match_o <= 1'b0;
        if (rst_i) begin
            expect_byte <= `IPNP_KEY_FIRST;
            count       <= 5'h00;
        end else if (wr_i) begin
            if (hit && count == `IPNP_KEY_LAST_IDX) begin
                match_o     <= 1'b1;
                expect_byte <= `IPNP_KEY_FIRST;
                count       <= 5'h00;
            end else if (hit) begin
                expect_byte <= key_next(expect_byte);
                count       <= count + 5'h01;
            end else if (data_i == `IPNP_KEY_FIRST) begin
                // a mismatching byte may itself start a new key
                expect_byte <= key_next(`IPNP_KEY_FIRST);
                count       <= 5'h01;
            end else begin
                expect_byte <= `IPNP_KEY_FIRST;
                count       <= 5'h00;
            end
        end
    end

endmodule // ipnp_key_det

// [ipnp_cfg_port.v]
`include "ipnp_regs.vh"

// Overview of operation
// - plug and play only with enable bit and strap
// - rest of card ignores bus until activated
// - decode index, write and relocatable read ports
// - index port writes load the index register
// - data ports access the indexed register
// - power-up, reset and wait-for-key enter WaitForKey
// - WaitForKey: no commands, data ports disabled
// - full initiation key enters Sleep
// - wrong key byte restarts key detection
// - card select number clears at power-up
// - matching wake goes Isolation or Configuration
// - non-matching wake sends card to Sleep
// - isolation one bit returns 0x55 then 0xAA
// - status bit 0 flags valid resource byte
// - activate bit transfers settings then enables card
// - unused registers and bits read zero
module ipnp_cfg_port (
    input  wire        CORE_CLK_I,
    input  wire        SYS_RST_I,
    input  wire [15:0] ISA_ADDR_I,
    input  wire        ISA_IOW_I,
    input  wire        ISA_IOR_I,
    input  wire [7:0]  ISA_DATA_I,
    output reg  [7:0]  ISA_DATA_O,
    output reg         ISA_DATA_OE_O,
    input  wire [7:0]  STORED_FEATURE_BYTE_I,
    input  wire        FEATURE_VALID_I,
    input  wire        STRAP_SENSE_PIN_I,
    input  wire        SERIAL_ID_BIT_I,
    output reg         SERIAL_ADV_O,
    input  wire [7:0]  RES_DATA_I,
    input  wire        RES_VALID_I,
    output reg         RES_TAKE_O,
    output reg         ACT_XFER_O,
    input  wire        XFER_DONE_I,
    output wire        CARD_ENABLE_O,
    output wire [1:0]  PNP_STATE_O
);

    localparam ST_WFK   = 2'b00;
    localparam ST_SLEEP = 2'b01;
    localparam ST_ISO   = 2'b10;
    localparam ST_CFG   = 2'b11;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [7:0] index;
    reg  [7:0] csn;
    reg  [7:0] rdport;
    reg        act_bit;
    reg        card_active;
    reg        pnp_on;
    reg        iow_q;
    reg        ior_q;
    reg        iso_read;
    reg        iso_drive;
    reg        iso_phase;
    reg        seen_first;
    reg  [7:0] bus_last;
    reg  [7:0] rd_val;
    wire       iow_rise;
    wire       ior_rise;
    wire       ior_fall;
    wire       idx_hit;
    wire       wr_hit;
    wire       rd_hit;
    wire       ports_on;
    wire       cfg_wr;
    wire       cfg_rd;
    wire       key_match;

    // ------------------------------------------------------------
    // strobes and decode
    // ------------------------------------------------------------
    assign iow_rise = ISA_IOW_I & ~iow_q;
    assign ior_rise = ISA_IOR_I & ~ior_q;
    assign ior_fall = ior_q & ~ISA_IOR_I;

    assign idx_hit  = pnp_on && (ISA_ADDR_I == `IPNP_INDEX_PORT);
    assign wr_hit   = pnp_on && (ISA_ADDR_I == `IPNP_WRITE_PORT);
    assign rd_hit   = pnp_on && (ISA_ADDR_I[15:9] == `IPNP_RD_RANGE_HI)
                      && (ISA_ADDR_I[9:2] == rdport)
                      && (ISA_ADDR_I[1:0] == `IPNP_RD_LOW_BITS);

    assign ports_on = (state != ST_WFK);
    assign cfg_wr   = iow_rise && wr_hit && ports_on;
    assign cfg_rd   = ior_rise && rd_hit && (state == ST_ISO || state == ST_CFG);

    assign CARD_ENABLE_O = ~pnp_on | card_active;
    assign PNP_STATE_O   = state;

    ipnp_key_det u_key (
        .clk_i   (CORE_CLK_I),
        .rst_i   (SYS_RST_I),
        .wr_i    (iow_rise && idx_hit),
        .data_i  (ISA_DATA_I),
        .match_o (key_match)
    );

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    always @* begin
        rd_val = 8'h00;
        if (index == `IPNP_REG_RDPORT) begin
            rd_val = rdport;
        end else if (index == `IPNP_REG_ISOLATE) begin
            rd_val = iso_phase ? `IPNP_ISO_SECOND : `IPNP_ISO_FIRST;
        end else if (index == `IPNP_REG_RESDATA) begin
            rd_val = RES_DATA_I;
        end else if (index == `IPNP_REG_STATUS) begin
            rd_val[`IPNP_STS_VALID_BIT] = RES_VALID_I;
        end else if (index == `IPNP_REG_CSN) begin
            rd_val = csn;
        end else if (index == `IPNP_REG_ACTIVATE) begin
            rd_val[`IPNP_ACT_BIT] = act_bit;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_WFK: begin
                if (key_match) begin
                    next_state = ST_SLEEP;
                end
            end
            default: begin
                if (cfg_wr && index == `IPNP_REG_CFGCTL &&
                    (ISA_DATA_I[`IPNP_CTL_RESET_BIT] || ISA_DATA_I[`IPNP_CTL_WFK_BIT])) begin
                    next_state = ST_WFK;
                end else if (cfg_wr && index == `IPNP_REG_WAKE) begin
                    if (ISA_DATA_I != csn) begin
                        next_state = ST_SLEEP;
                    end else if (csn == 8'h00) begin
                        next_state = ST_ISO;
                    end else begin
                        next_state = ST_CFG;
                    end
                end else if (state == ST_ISO && cfg_wr && index == `IPNP_REG_CSN) begin
                    next_state = ST_CFG;
                end else if (state == ST_ISO && ior_fall && iso_read && !iso_drive &&
                             iso_phase && seen_first &&
                             bus_last == `IPNP_ISO_SECOND) begin
                    next_state = ST_SLEEP;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always @(posedge CORE_CLK_I) begin
        SERIAL_ADV_O <= 1'b0;
        RES_TAKE_O   <= 1'b0;
        ACT_XFER_O   <= 1'b0;
        if (SYS_RST_I) begin
            state         <= ST_WFK;
            index         <= `IPNP_INDEX_RESET;
            csn           <= `IPNP_CSN_RESET;
            rdport        <= `IPNP_RDPORT_RESET;
            act_bit       <= 1'b0;
            card_active   <= 1'b0;
            pnp_on        <= 1'b0;
            iow_q         <= 1'b0;
            ior_q         <= 1'b0;
            iso_read      <= 1'b0;
            iso_drive     <= 1'b0;
            iso_phase     <= 1'b0;
            seen_first    <= 1'b0;
            bus_last      <= 8'h00;
            ISA_DATA_O    <= 8'h00;
            ISA_DATA_OE_O <= 1'b0;
        end else begin
            state <= next_state;
            iow_q <= ISA_IOW_I;
            ior_q <= ISA_IOR_I;
            if (FEATURE_VALID_I) begin
                pnp_on <= STORED_FEATURE_BYTE_I[`IPNP_FEAT_EN_BIT] & STRAP_SENSE_PIN_I;
            end
            if (iow_rise && idx_hit) begin
                index <= ISA_DATA_I;
            end
            if (next_state == ST_ISO && state != ST_ISO) begin
                iso_phase  <= 1'b0;
                seen_first <= 1'b0;
            end
            // write side effects
            if (cfg_wr) begin
                if (index == `IPNP_REG_CFGCTL && ISA_DATA_I[`IPNP_CTL_RSTCSN_BIT]) begin
                    csn <= `IPNP_CSN_RESET;
                end else if (index == `IPNP_REG_CSN && (state == ST_ISO || state == ST_CFG)) begin
                    csn <= ISA_DATA_I;
                end else if (index == `IPNP_REG_RDPORT && state == ST_ISO) begin
                    rdport <= ISA_DATA_I;
                end else if (index == `IPNP_REG_ACTIVATE && state == ST_CFG) begin
                    act_bit <= ISA_DATA_I[`IPNP_ACT_BIT];
                    if (ISA_DATA_I[`IPNP_ACT_BIT] && !act_bit) begin
                        ACT_XFER_O <= 1'b1;
                    end
                    if (!ISA_DATA_I[`IPNP_ACT_BIT]) begin
                        card_active <= 1'b0;
                    end
                end
            end
            if (XFER_DONE_I && act_bit) begin
                card_active <= 1'b1;
            end
            // read data port
            if (cfg_rd) begin
                ISA_DATA_O <= rd_val;
                if (index == `IPNP_REG_ISOLATE) begin
                    iso_read      <= (state == ST_ISO);
                    iso_drive     <= SERIAL_ID_BIT_I;
                    ISA_DATA_OE_O <= (state == ST_ISO) && SERIAL_ID_BIT_I;
                end else begin
                    ISA_DATA_OE_O <= 1'b1;
                    if (index == `IPNP_REG_RESDATA) begin
                        RES_TAKE_O <= 1'b1;
                    end
                end
            end else if (!ISA_IOR_I) begin
                ISA_DATA_OE_O <= 1'b0;
            end
            // isolation bus watch while another card may drive
            if (ISA_IOR_I && iso_read) begin
                bus_last <= ISA_DATA_I;
            end
            if (ior_fall && iso_read) begin
                iso_read   <= 1'b0;
                iso_phase  <= ~iso_phase;
                seen_first <= !iso_drive && (bus_last == `IPNP_ISO_FIRST);
                // no advance when the card drops out to sleep
                if (iso_phase && next_state == ST_ISO) begin
                    SERIAL_ADV_O <= 1'b1;
                end
            end
        end
    end

endmodule // ipnp_cfg_port

// [ipnp_cfg_port_chk.sv]
module ipnp_cfg_port_chk (
    input wire       CORE_CLK_I,
    input wire       SYS_RST_I,
    input wire       ISA_IOW_I,
    input wire       ISA_IOR_I,
    input wire       ISA_DATA_OE_O,
    input wire       SERIAL_ADV_O,
    input wire       RES_TAKE_O,
    input wire       ACT_XFER_O,
    input wire [1:0] PNP_STATE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // -----------------------------
    // single-cycle pulse in a state
    // -----------------------------
    sequence s_one(cond, sig);
        cond ##1 !sig;
    endsequence
    chk_reset_idle: assert property ($fell(SYS_RST_I) |-> PNP_STATE_O == 2'h0 && !ISA_DATA_OE_O)
        else $error("not idle after reset");
    chk_oe_release: assert property (!ISA_IOR_I |=> !ISA_DATA_OE_O)
        else $error("drive held after read");
    chk_wfk_quiet: assert property (PNP_STATE_O == 2'h0 && ISA_IOR_I |=> !ISA_DATA_OE_O)
        else $error("drive while waiting for key");
    chk_sleep_quiet: assert property (PNP_STATE_O == 2'h1 && ISA_IOR_I |=> !ISA_DATA_OE_O)
        else $error("drive while asleep");
    chk_oe_cause: assert property ($rose(ISA_DATA_OE_O) |-> $past(ISA_IOR_I) && PNP_STATE_O[1])
        else $error("drive without read");
    chk_adv_pulse: assert property (SERIAL_ADV_O |-> s_one(!ISA_IOR_I && PNP_STATE_O == 2'h2, SERIAL_ADV_O))
        else $error("bad serial advance");
    chk_take_pulse: assert property (RES_TAKE_O |-> s_one(PNP_STATE_O == 2'h3, RES_TAKE_O))
        else $error("bad resource take");
    chk_act_pulse: assert property (ACT_XFER_O |-> s_one(PNP_STATE_O == 2'h3, ACT_XFER_O))
        else $error("bad transfer start");
    chk_state_cause: assert property (($changed(PNP_STATE_O) && !($past(PNP_STATE_O) == 2'h2 && PNP_STATE_O == 2'h1)) |-> $past(ISA_IOW_I) || $past(ISA_IOW_I, 2))
        else $error("state change without write");
endmodule // ipnp_cfg_port_chk

bind ipnp_cfg_port ipnp_cfg_port_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .ISA_IOW_I(ISA_IOW_I), .ISA_IOR_I(ISA_IOR_I), .ISA_DATA_OE_O(ISA_DATA_OE_O),
    .SERIAL_ADV_O(SERIAL_ADV_O), .RES_TAKE_O(RES_TAKE_O), .ACT_XFER_O(ACT_XFER_O),
    .PNP_STATE_O(PNP_STATE_O));

// [ipnp_host.sv]
module ipnp_host (
    input  wire         clk_i,
    input  wire  [7:0]  dout_i,
    input  wire         oe_i,
    input  wire  [7:0]  alt_i,
    output logic [15:0] addr_o,
    output logic        iow_o,
    output logic        ior_o,
    output wire  [7:0]  bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       drv = 1'b0;
    logic [7:0] wd = 8'h00;
    // released bus shows another card, or pull-ups when alt_i is FF
    assign bus_o = drv ? wd : (oe_i ? dout_i : alt_i);
    initial begin
        addr_o = 16'h0000;
        iow_o = 1'b0;
        ior_o = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk_i);
        addr_o = a;
        wd = v;
        drv = 1'b1;
        iow_o = 1'b1;
        @(negedge clk_i);
        iow_o = 1'b0;
        drv = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v, output logic e);
        @(negedge clk_i);
        addr_o = a;
        ior_o = 1'b1;
        repeat (2) @(negedge clk_i);
        v = bus_o;
        e = oe_i;
        ior_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule // ipnp_host

// [testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0;
    logic       rst = 1;
    logic [7:0] feat = 8'h01;
    logic       fv = 0;
    logic       strap = 0;
    logic [7:0] res = 8'hC3;
    logic       rv = 1;
    logic       done = 0;
    logic       sid = 1;
    logic [7:0] alt = 8'hFF;
    logic [7:0] d;
    logic       o;
    wire [15:0] addr;
    wire [7:0]  bus, dout;
    wire [1:0]  st;
    wire        iow, ior, oe, adv, take, act, cen;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int n_adv = 0;
    int n_take = 0;
    int n_act = 0;

    ipnp_cfg_port dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .ISA_ADDR_I(addr), .ISA_IOW_I(iow),
        .ISA_IOR_I(ior), .ISA_DATA_I(bus), .ISA_DATA_O(dout), .ISA_DATA_OE_O(oe),
        .STORED_FEATURE_BYTE_I(feat), .FEATURE_VALID_I(fv), .STRAP_SENSE_PIN_I(strap),
        .SERIAL_ID_BIT_I(sid), .SERIAL_ADV_O(adv), .RES_DATA_I(res), .RES_VALID_I(rv),
        .RES_TAKE_O(take), .ACT_XFER_O(act), .XFER_DONE_I(done), .CARD_ENABLE_O(cen),
        .PNP_STATE_O(st));
    ipnp_host host (.clk_i(clk), .dout_i(dout), .oe_i(oe), .alt_i(alt), .addr_o(addr), .iow_o(iow),
        .ior_o(ior), .bus_o(bus));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        n_adv += (adv === 1'b1);
        n_take += (take === 1'b1);
        n_act += (act === 1'b1);
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic iwr(input logic [7:0] i, input logic [7:0] v);
        host.wr(16'h0279, i);
        host.wr(16'h0A79, v);
    endtask
    task automatic ird(input logic [7:0] i);
        host.wr(16'h0279, i);
        host.rd(16'h0203, d, o);
    endtask
    // bad selects one key byte to corrupt, 32 for none
    task automatic key(input int bad);
        logic [7:0] b;
        b = 8'h6A;
        for (int k = 0; k < 32; k++) begin
            host.wr(16'h0279, (k == bad) ? 8'h00 : b);
            b = {b[0] ^ b[1], b[7:1]};
        end
        @(negedge clk);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        @(negedge clk);
        check({7'h00, cen}, 8'h01);
        check({6'h00, st}, 8'h00);
        fv = 1;
        key(32);
        check({6'h00, st}, 8'h00);
        strap = 1;
        @(negedge clk);
        check({7'h00, cen}, 8'h00);
        iwr(8'h03, 8'h00);
        ird(8'h01);
        check({6'h00, st}, 8'h00);
        check({7'h00, o}, 8'h00);
        key(16);
        check({6'h00, st}, 8'h00);
        key(32);
        check({6'h00, st}, 8'h01);
        ird(8'h01);
        check({7'h00, o}, 8'h00);
        iwr(8'h03, 8'h00);
        check({6'h00, st}, 8'h02);
        iwr(8'h00, 8'h80);
        ird(8'h01);
        check(d, 8'h55);
        check({7'h00, o}, 8'h01);
        host.rd(16'h0203, d, o);
        check(d, 8'hAA);
        @(negedge clk);
        check(n_adv[7:0], 8'h01);
        sid = 0;
        host.rd(16'h0203, d, o);
        check({7'h00, o}, 8'h00);
        check(d, 8'hFF);
        host.rd(16'h0203, d, o);
        check({6'h00, st}, 8'h02);
        check(n_adv[7:0], 8'h02);
        sid = 1;
        iwr(8'h06, 8'h05);
        check({6'h00, st}, 8'h03);
        ird(8'h05);
        check(d, 8'h01);
        ird(8'h04);
        check(d, 8'hC3);
        check(n_take[7:0], 8'h01);
        rv = 0;
        ird(8'h05);
        check(d, 8'h00);
        ird(8'h07);
        check(d, 8'h00);
        iwr(8'h30, 8'h01);
        @(negedge clk);
        check(n_act[7:0], 8'h01);
        check({7'h00, cen}, 8'h00);
        done = 1;
        @(negedge clk);
        check({7'h00, cen}, 8'h01);
        iwr(8'h03, 8'h07);
        check({6'h00, st}, 8'h01);
        iwr(8'h03, 8'h05);
        check({6'h00, st}, 8'h03);
        iwr(8'h02, 8'h04);
        check({6'h00, st}, 8'h03);
        iwr(8'h03, 8'h00);
        check({6'h00, st}, 8'h02);
        iwr(8'h02, 8'h02);
        check({6'h00, st}, 8'h00);
        ird(8'h06);
        check({7'h00, o}, 8'h00);
        iwr(8'h03, 8'h00);
        check({6'h00, st}, 8'h00);
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (2) @(negedge clk);
        key(32);
        iwr(8'h03, 8'h00);
        check({6'h00, st}, 8'h02);
        iwr(8'h00, 8'h80);
        sid = 0;
        alt = 8'h55;
        ird(8'h01);
        check(d, 8'h55);
        check({7'h00, o}, 8'h00);
        alt = 8'hAA;
        host.rd(16'h0203, d, o);
        check({6'h00, st}, 8'h01);
        alt = 8'hFF;
        iwr(8'h02, 8'h01);
        check({6'h00, st}, 8'h00);
        final_report();
    end
endmodule // testbench
